// [cedr_regs.sv]
`timescale 1ns/10ps
module cedr_regs
	import cedr_pkg::*;
#(
	parameter int STEP_CYC = DLY_STEP_CYC
)
(
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        CE,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [7:0]  REG_WDATA,
	output logic      [7:0]  REG_RDATA,
	input  wire logic        OTP_LOAD,
	input  wire logic [7:0]  OTP_SD1_VCODE,
	input  wire logic        EXT_ON_INPUT_1,
	input  wire logic        EXT_ON_INPUT_2,
	input  wire logic        EXT_ON_INPUT_3,
	input  wire logic        STEPDOWN0_CTRL,
	input  wire logic        DELAY_SCALE,
	output logic             STEPDOWN0_ON,
	output logic             STEPDOWN1_ON,
	output logic             STEPUP_ON,
	output logic             STEPDOWN1_DISCHARGE,
	output logic             STEPUP_DISCHARGE,
	output logic      [12:0] STEPDOWN1_TARGET_MV,
	output logic             STEPDOWN1_CODE_RESERVED,
	output logic      [12:0] STEPUP_TARGET_MV
);

	//==========================================================
	// decode helpers
	function automatic logic gated_on(input logic on_bit, input logic [1:0] sel,
		input logic in1, input logic in2, input logic in3);
		logic pin;
		unique case (cedr_gate_type'(sel))
			CEDR_GATE_NONE: pin = 1'b1;
			CEDR_GATE_IN1:  pin = in1;
			CEDR_GATE_IN2:  pin = in2;
			CEDR_GATE_IN3:  pin = in3;
		endcase
		return on_bit & pin;
	endfunction : gated_on

	function automatic logic [12:0] code_to_mv(input logic [7:0] code);
		logic [12:0] mv;
		mv = 13'd0;
		if (code >= VC_HI_FIRST)
			mv = MV_HI_BASE + MV_HI_STEP * 13'(code - VC_HI_FIRST);
		else if (code >= VC_MID_FIRST)
			mv = MV_MID_BASE + MV_MID_STEP * 13'(code - VC_MID_FIRST);
		else if (code >= VC_LOW_FIRST)
			mv = MV_LOW_BASE + MV_LOW_STEP * 13'(code - VC_LOW_FIRST);
		return mv;
	endfunction : code_to_mv

	//==========================================================
	// register storage
	logic [7:0] sd1_ctrl_ff;
	logic [7:0] sd1_vcode_ff;
	logic [7:0] su_ctrl_ff;
	logic [7:0] delay_ff [3];
	logic [7:0] rdata_ff;

	wire        wr_sd1_ctrl  = REG_WR && REG_ADDR == OFS_SD1_CTRL;
	wire        wr_sd1_vcode = REG_WR && REG_ADDR == OFS_SD1_VCODE;
	wire        wr_su_ctrl   = REG_WR && REG_ADDR == OFS_SU_CTRL;

	// otp load takes priority over a software write landing in the same cycle
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sd1_ctrl_ff  <= RST_SD1_CTRL;
			sd1_vcode_ff <= RST_SD1_VCODE;
			su_ctrl_ff   <= RST_SU_CTRL;
		end
		else if (CE)
		begin
			if (wr_sd1_ctrl)
				sd1_ctrl_ff <= REG_WDATA;
			if (OTP_LOAD)
				sd1_vcode_ff <= OTP_SD1_VCODE;
			else if (wr_sd1_vcode)
				sd1_vcode_ff <= REG_WDATA;
			if (wr_su_ctrl)
				su_ctrl_ff <= REG_WDATA;
		end
	end

	//==========================================================
	// delay registers and timers, index 0 step-down 0, 1 step-down 1, 2 step-up
	logic [2:0] ctrl_sig;
	logic [2:0] conv_on;

	assign ctrl_sig[0] = STEPDOWN0_CTRL;
	assign ctrl_sig[1] = gated_on(sd1_ctrl_ff[BIT_ON], sd1_ctrl_ff[GATE_MSB:GATE_LSB],
		EXT_ON_INPUT_1, EXT_ON_INPUT_2, EXT_ON_INPUT_3);
	assign ctrl_sig[2] = gated_on(su_ctrl_ff[BIT_ON], su_ctrl_ff[GATE_MSB:GATE_LSB],
		EXT_ON_INPUT_1, EXT_ON_INPUT_2, EXT_ON_INPUT_3);

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_conv
			wire wr_delay = REG_WR && REG_ADDR == OFS_SD0_DELAY + 8'(gi);

			always_ff @(posedge CLK or negedge RST_N)
			begin
				if (!RST_N)
					delay_ff[gi] <= RST_DELAY;
				else if (CE && wr_delay)
					delay_ff[gi] <= REG_WDATA;
			end

			cedr_seq_timer #(
				.STEP_CYC (STEP_CYC)
			) u_timer (
				.clk       (CLK),
				.rst_n     (RST_N),
				.ce        (CE),
				.ctrl      (ctrl_sig[gi]),
				.on_delay  (delay_ff[gi][ON_DLY_MSB:ON_DLY_LSB]),
				.off_delay (delay_ff[gi][OFF_DLY_MSB:OFF_DLY_LSB]),
				.scale     (DELAY_SCALE),
				.state     (conv_on[gi])
			);
		end
	endgenerate

	//==========================================================
	// read port, one cycle latency; unmapped offsets read zero
	logic [7:0] rd_mux;

	always_comb
	begin
		unique case (REG_ADDR)
			OFS_SD1_CTRL:  rd_mux = sd1_ctrl_ff;
			OFS_SD1_VCODE: rd_mux = sd1_vcode_ff;
			OFS_SU_CTRL:   rd_mux = su_ctrl_ff;
			OFS_SD0_DELAY: rd_mux = delay_ff[0];
			OFS_SD1_DELAY: rd_mux = delay_ff[1];
			OFS_SU_DELAY:  rd_mux = delay_ff[2];
			default:       rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			rdata_ff <= 8'h00;
		else if (CE && REG_RD)
			rdata_ff <= rd_mux;
	end

	//==========================================================
	// outputs
	logic        sd1_dis_ff;
	logic        su_dis_ff;
	logic [12:0] sd1_mv_ff;
	logic        sd1_rsv_ff;
	logic [12:0] su_mv_ff;

	// reserved codes give 0 mv and a flag; the converter must not be asked for them
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sd1_dis_ff <= 1'b0;
			su_dis_ff  <= 1'b0;
			sd1_mv_ff  <= 13'h0000;
			sd1_rsv_ff <= 1'b1;
			su_mv_ff   <= MV_SU_BASE;
		end
		else if (CE)
		begin
			sd1_dis_ff <= sd1_ctrl_ff[BIT_DISCHARGE] & ~conv_on[1];
			su_dis_ff  <= su_ctrl_ff[BIT_DISCHARGE] & ~conv_on[2];
			sd1_mv_ff  <= code_to_mv(sd1_vcode_ff);
			sd1_rsv_ff <= sd1_vcode_ff < VC_LOW_FIRST;
			su_mv_ff   <= MV_SU_BASE + MV_SU_STEP * 13'(su_ctrl_ff[SU_VSET_MSB:SU_VSET_LSB]);
		end
	end

	assign REG_RDATA               = rdata_ff;
	assign STEPDOWN0_ON            = conv_on[0];
	assign STEPDOWN1_ON            = conv_on[1];
	assign STEPUP_ON               = conv_on[2];
	assign STEPDOWN1_DISCHARGE     = sd1_dis_ff;
	assign STEPUP_DISCHARGE        = su_dis_ff;
	assign STEPDOWN1_TARGET_MV     = sd1_mv_ff;
	assign STEPDOWN1_CODE_RESERVED = sd1_rsv_ff;
	assign STEPUP_TARGET_MV        = su_mv_ff;

endmodule : cedr_regs

// [cedr_pkg.sv]
//==========================================================
package cedr_pkg;

	//==========================================================
	// register offsets
	localparam logic [7:0] OFS_SD1_CTRL  = 8'h04;
	localparam logic [7:0] OFS_SD1_VCODE = 8'h07;
	localparam logic [7:0] OFS_SU_CTRL   = 8'h08;
	localparam logic [7:0] OFS_SD0_DELAY = 8'h09;
	localparam logic [7:0] OFS_SD1_DELAY = 8'h0a;
	localparam logic [7:0] OFS_SU_DELAY  = 8'h0b;

	//==========================================================
	// reset values
	localparam logic [7:0] RST_SD1_CTRL  = 8'h08;
	localparam logic [7:0] RST_SD1_VCODE = 8'h00;
	localparam logic [7:0] RST_SU_CTRL   = 8'h08;
	localparam logic [7:0] RST_DELAY     = 8'h00;

	//==========================================================
	// field positions (control registers share the on, gate and discharge bits; the vset field is step-up only)
	localparam int BIT_ON        = 0;
	localparam int GATE_LSB      = 1;
	localparam int GATE_MSB      = 2;
	localparam int BIT_DISCHARGE = 3;
	localparam int SU_VSET_LSB   = 6;
	localparam int SU_VSET_MSB   = 7;
	localparam int ON_DLY_LSB    = 0;
	localparam int ON_DLY_MSB    = 3;
	localparam int OFF_DLY_LSB   = 4;
	localparam int OFF_DLY_MSB   = 7;

	//==========================================================
	// voltage code table, millivolts
	localparam logic [7:0]  VC_LOW_FIRST = 8'h14;
	localparam logic [7:0]  VC_MID_FIRST = 8'h18;
	localparam logic [7:0]  VC_HI_FIRST  = 8'h9e;
	localparam logic [12:0] MV_LOW_BASE  = 13'd700;
	localparam logic [12:0] MV_MID_BASE  = 13'd735;
	localparam logic [12:0] MV_HI_BASE   = 13'd1420;
	localparam logic [12:0] MV_LOW_STEP  = 13'd10;
	localparam logic [12:0] MV_MID_STEP  = 13'd5;
	localparam logic [12:0] MV_HI_STEP   = 13'd20;
	localparam logic [12:0] MV_SU_BASE   = 13'd4900;
	localparam logic [12:0] MV_SU_STEP   = 13'd100;

	//==========================================================
	// timing
	localparam int CLK_MHZ       = 200;
	localparam int DLY_STEP_US   = 500;
	localparam int DLY_STEP_CYC  = DLY_STEP_US * CLK_MHZ;

	typedef enum logic [1:0]
	{
		CEDR_GATE_NONE,
		CEDR_GATE_IN1,
		CEDR_GATE_IN2,
		CEDR_GATE_IN3
	} cedr_gate_type;

endpackage : cedr_pkg

// [cedr_seq_timer.sv]
`timescale 1ns/10ps
module cedr_seq_timer
	import cedr_pkg::*;
#(
	parameter int STEP_CYC = DLY_STEP_CYC
)
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       ctrl,
	input  wire logic [3:0] on_delay,
	input  wire logic [3:0] off_delay,
	input  wire logic       scale,
	output logic            state
);

	localparam int PW = $clog2(2 * STEP_CYC + 1);

	logic          ctrl_ff;
	logic          state_ff;
	logic          pend_ff;
	logic [3:0]    steps_ff;
	logic [PW-1:0] pre_ff;

	wire           edge_seen = ctrl != ctrl_ff;
	wire  [PW-1:0] step_last = scale ? PW'(2 * STEP_CYC - 1) : PW'(STEP_CYC - 1);
	wire           step_done = pre_ff == step_last;
	wire  [3:0]    load_val  = ctrl ? on_delay : off_delay;

	assign state = state_ff;

	// an opposite edge mid-count reloads; the output only follows once the count runs out
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_ff  <= 1'b0;
			state_ff <= 1'b0;
			pend_ff  <= 1'b0;
			steps_ff <= 4'h0;
			pre_ff   <= '0;
		end
		else if (ce)
		begin
			ctrl_ff <= ctrl;
			if (edge_seen)
			begin
				pend_ff  <= 1'b1;
				steps_ff <= load_val;
				pre_ff   <= '0;
			end
			else if (pend_ff)
			begin
				if (steps_ff == 4'h0)
				begin
					state_ff <= ctrl_ff;
					pend_ff  <= 1'b0;
				end
				else if (step_done)
				begin
					pre_ff   <= '0;
					steps_ff <= steps_ff - 4'h1;
				end
				else
				begin
					pre_ff <= pre_ff + PW'(1);
				end
			end
		end
	end

endmodule : cedr_seq_timer

// [cedr_regs_sva.sv]
`timescale 1ns/10ps
module cedr_regs_sva
(
	input wire logic        CLK,
	input wire logic        RST_N,
	input wire logic        CE,
	input wire logic [7:0]  REG_ADDR,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [7:0]  REG_WDATA,
	input wire logic [7:0]  REG_RDATA,
	input wire logic        OTP_LOAD,
	input wire logic [7:0]  OTP_SD1_VCODE,
	input wire logic        STEPDOWN1_ON,
	input wire logic        STEPUP_ON,
	input wire logic        STEPDOWN1_DISCHARGE,
	input wire logic        STEPUP_DISCHARGE,
	input wire logic [12:0] STEPDOWN1_TARGET_MV,
	input wire logic        STEPDOWN1_CODE_RESERVED,
	input wire logic [12:0] STEPUP_TARGET_MV
);
	//==========================================================
	// checks
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	wire wr_vcode = REG_WR && REG_ADDR == 8'h07;
	rd_unmap_a: assert property (CE && REG_RD && REG_ADDR > 8'h0b |=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	rd_hold_a: assert property (!(CE && REG_RD) |=> $stable(REG_RDATA))
		else $error("read data moved without a read");
	rd_back_a: assert property (CE && REG_WR && REG_ADDR == 8'h09 ##1 !REG_WR
		##1 CE && REG_RD && !REG_WR && REG_ADDR == 8'h09
		|=> REG_RDATA == $past(REG_WDATA, 3)) else $error("delay register read back wrong");
	freeze_a: assert property (!CE |=> $stable(STEPUP_ON) && $stable(STEPDOWN1_ON))
		else $error("state moved while frozen");
	res_zero_a: assert property (STEPDOWN1_CODE_RESERVED |-> STEPDOWN1_TARGET_MV == 13'h0)
		else $error("reserved code gives a target");
	otp_res_a: assert property (CE && OTP_LOAD && OTP_SD1_VCODE < 8'h14 ##1 CE && !OTP_LOAD && !wr_vcode
		|=> STEPDOWN1_CODE_RESERVED) else $error("otp code not loaded");
	su_volt_a: assert property (STEPUP_TARGET_MV inside {13'h1324, 13'h1388, 13'h13ec, 13'h1450})
		else $error("step-up target off grid");
	su_dis_a: assert property (STEPUP_ON && $past(STEPUP_ON) |-> !STEPUP_DISCHARGE)
		else $error("step-up discharge while on");
	sd1_dis_a: assert property (STEPDOWN1_ON && $past(STEPDOWN1_ON) |-> !STEPDOWN1_DISCHARGE)
		else $error("step-down discharge while on");
	cover property (STEPUP_ON && STEPDOWN1_ON);
	cover property (CE && STEPDOWN1_CODE_RESERVED);
	cover property (CE && REG_RD && REG_ADDR > 8'h0b);
endmodule : cedr_regs_sva

// [cedr_regs_tb.sv]
`timescale 1ns/10ps
module cedr_regs_tb;
	import cedr_pkg::*;
	localparam int S = 4;
	logic        CLK = 1'h0, RST_N = 1'h0, CE = 1'h1, REG_WR = 1'h0, REG_RD = 1'h0, OTP_LOAD = 1'h0;
	logic        EXT_ON_INPUT_1 = 1'h0, EXT_ON_INPUT_2 = 1'h0, EXT_ON_INPUT_3 = 1'h0;
	logic        STEPDOWN0_CTRL = 1'h0, DELAY_SCALE = 1'h0;
	logic [7:0]  REG_ADDR = 8'h00, REG_WDATA = 8'h00, OTP_SD1_VCODE = 8'h00, REG_RDATA;
	logic        STEPDOWN0_ON, STEPDOWN1_ON, STEPUP_ON, STEPDOWN1_DISCHARGE, STEPUP_DISCHARGE;
	logic        STEPDOWN1_CODE_RESERVED;
	logic [12:0] STEPDOWN1_TARGET_MV, STEPUP_TARGET_MV;
	logic [2:0]  p;
	int          err_count = 0, checked = 0, n;
	always #2.5 CLK = ~CLK;
	cedr_regs #(.STEP_CYC(S)) dut (.*);
	//==========================================================
	// helpers
	task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(negedge CLK);
	endtask : cyc
	// one idle edge first, so a strobe dropped by the last access is never raised again in the same step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cyc(1);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = 1'h1;
		cyc(1);
		REG_WR = 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		cyc(1);
		REG_ADDR = a;
		REG_RD = 1'h1;
		cyc(1);
		REG_RD = 1'h0;
		chk(REG_RDATA, e);
	endtask : rd
	function automatic logic onv(input int k);
		return k == 0 ? STEPDOWN0_ON : k == 1 ? STEPDOWN1_ON : STEPUP_ON;
	endfunction : onv
	// the edge is seen one or two samples after our drive, so allow one cycle of slack
	task automatic meas(input int k, input logic v, input int lo);
		n = 0;
		while (onv(k) !== v && n < 300)
		begin
			cyc(1);
			n++;
		end
		chk(n >= lo && n <= lo + 1, 1'h1);
	endtask : meas
	function automatic logic [12:0] mv(input logic [7:0] c);
		if (c < 8'h14)
			return 13'h0;
		if (c < 8'h18)
			return MV_LOW_BASE + 13'(c - 8'h14) * MV_LOW_STEP;
		if (c < 8'h9e)
			return MV_MID_BASE + 13'(c - 8'h18) * MV_MID_STEP;
		return MV_HI_BASE + 13'(c - 8'h9e) * MV_HI_STEP;
	endfunction : mv
	//==========================================================
	// scenarios
	task automatic t_reset();
		chk(STEPDOWN0_ON | STEPDOWN1_ON | STEPUP_ON, 1'h0);
		chk(STEPUP_TARGET_MV, 13'h1324);
		// discharge flops leave reset low and follow the set bit one edge later
		cyc(2);
		chk(STEPUP_DISCHARGE & STEPDOWN1_DISCHARGE, 1'h1);
		chk(STEPDOWN1_CODE_RESERVED, 1'h1);
		chk(STEPDOWN1_TARGET_MV, 13'h0000);
		rd(8'h04, 8'h08);
		rd(8'h07, 8'h00);
		rd(8'h08, 8'h08);
		for (int a = 9; a < 12; a++)
			rd(8'(a), 8'h00);
		rd(8'h0c, 8'h00);
	endtask : t_reset
	task automatic t_rw();
		for (int a = 9; a < 12; a++)
		begin
			wr(8'(a), 8'ha5 ^ 8'(a));
			rd(8'(a), 8'ha5 ^ 8'(a));
		end
		wr(8'h0c, 8'hff);
		rd(8'h0c, 8'h00);
		CE = 1'h0;
		wr(8'h09, 8'h33);
		CE = 1'h1;
		rd(8'h09, 8'hac);
		OTP_SD1_VCODE = 8'h20;
		OTP_LOAD = 1'h1;
		wr(8'h07, 8'h40);
		OTP_LOAD = 1'h0;
		rd(8'h07, 8'h20);
		wr(8'h09, 8'h00);
		wr(8'h0a, 8'h00);
		wr(8'h0b, 8'h00);
	endtask : t_rw
	task automatic t_volt();
		logic [7:0] codes [7] = '{8'h14, 8'h16, 8'h17, 8'h18, 8'h9d, 8'h9e, 8'hff};
		// software keeps off the reserved codes; only the otp path may bring one in
		OTP_SD1_VCODE = 8'h13;
		OTP_LOAD = 1'h1;
		cyc(1);
		OTP_LOAD = 1'h0;
		cyc(2);
		chk(STEPDOWN1_CODE_RESERVED, 1'h1);
		chk(STEPDOWN1_TARGET_MV, 13'h0000);
		rd(8'h07, 8'h13);
		foreach (codes[i])
		begin
			wr(8'h07, codes[i]);
			cyc(2);
			chk(STEPDOWN1_TARGET_MV, mv(codes[i]));
			chk(STEPDOWN1_CODE_RESERVED, codes[i] < 8'h14);
		end
		for (int v = 0; v < 4; v++)
		begin
			wr(8'h08, {2'(v), 6'h08});
			cyc(2);
			chk(STEPUP_TARGET_MV, MV_SU_BASE + MV_SU_STEP * 13'(v));
		end
	endtask : t_volt
	task automatic t_gate();
		for (int g = 0; g < 4; g++)
		begin
			p = 3'(4'h1 << g >> 1);
			{EXT_ON_INPUT_3, EXT_ON_INPUT_2, EXT_ON_INPUT_1} = ~p;
			wr(8'h04, 8'h09 | 8'(g << 1));
			wr(8'h08, 8'h09 | 8'(g << 1));
			cyc(4);
			chk(STEPDOWN1_ON, g == 0);
			chk(STEPUP_ON, g == 0);
			chk(STEPUP_DISCHARGE, g != 0);
			chk(STEPDOWN1_DISCHARGE, g != 0);
			{EXT_ON_INPUT_3, EXT_ON_INPUT_2, EXT_ON_INPUT_1} = p;
			cyc(4);
			chk({STEPDOWN1_ON, STEPUP_ON}, 2'h3);
			wr(8'h04, 8'h00);
			wr(8'h08, 8'h00);
			cyc(4);
			chk({STEPDOWN1_ON, STEPUP_ON, STEPUP_DISCHARGE}, 3'h0);
		end
	endtask : t_gate
	task automatic t_delay();
		wr(8'h0b, 8'h23);
		for (int sc = 0; sc < 2; sc++)
		begin
			DELAY_SCALE = 1'(sc);
			wr(8'h08, 8'h01);
			meas(2, 1'h1, 2 + 3 * S * (sc + 1));
			wr(8'h08, 8'h00);
			meas(2, 1'h0, 2 + 2 * S * (sc + 1));
		end
		DELAY_SCALE = 1'h0;
		wr(8'h0a, 8'hf0);
		wr(8'h04, 8'h01);
		meas(1, 1'h1, 2);
		wr(8'h04, 8'h00);
		meas(1, 1'h0, 2 + 15 * S);
		wr(8'h09, 8'h04);
		STEPDOWN0_CTRL = 1'h1;
		cyc(5);
		STEPDOWN0_CTRL = 1'h0;
		cyc(40);
		chk(STEPDOWN0_ON, 1'h0);
		STEPDOWN0_CTRL = 1'h1;
		meas(0, 1'h1, 2 + 4 * S);
	endtask : t_delay
	task automatic stop_test();
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	//==========================================================
	// run
	initial
	begin
		#200us;
		err_count++;
		stop_test();
	end
	initial
	begin
		cyc(10);
		RST_N = 1'h1;
		t_reset();
		t_rw();
		t_volt();
		t_gate();
		t_delay();
		stop_test();
	end
endmodule : cedr_regs_tb
bind cedr_regs cedr_regs_sva chk (.*);
